/* File: hdl/ifcr_pkg.sv */
// Register map, field layout, timing and types of the inductive front-end register bank
package ifcr_pkg;
    localparam int unsigned CLK_PERIOD_NS = 8;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_GAIN = 8'h01;
    localparam logic [7:0] IDX_CTRL = 8'h03;
    localparam logic [7:0] IDX_STAT = 8'h04;
    localparam logic [7:0] IDX_ROUTE = 8'h10;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
    localparam int unsigned ADDR_IDX_LSB = 2;
    localparam int unsigned CODE_W = 6;
    localparam int unsigned GAIN_COARSE_LSB = 8;
    localparam int unsigned GAIN_FINE_LSB = 0;
    localparam int unsigned CTRL_EXT_DIS_BIT = 15;
    localparam int unsigned CTRL_COIL_RUN_BIT = 13;
    localparam int unsigned CTRL_TURN_CLR_BIT = 11;
    localparam int unsigned STAT_OPEN_BIT = 13;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] ROUTE_RESET = 16'h0000;
    localparam logic [5:0] CODE_RESET = 6'h00;
    localparam logic [5:0] CODE_MAX = 6'h3F;
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam int unsigned IRQ_OPEN_BIT = 1;
    localparam int unsigned IRQ_GAIN_BIT = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam int unsigned NUM_RECT = 4;
    localparam int unsigned NUM_COILS = 8;
    localparam int unsigned PEAK_W = 12;
    localparam logic [11:0] PEAK_HIGH_DEF = 12'hE00;
    localparam logic [11:0] PEAK_LOW_DEF = 12'h800;
    localparam int unsigned GAIN_PERIOD_DEF = 5000;
    // Coil excitation settle time before the open test samples
    localparam int unsigned COIL_SETTLE_NS = 2000;
    localparam int unsigned COIL_SETTLE_CYC =
        (COIL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [2:0] pos_pin;
        logic [2:0] neg_pin;
        logic neg_dc;
    } ifcr_rect_route_t;

    typedef struct packed {
        logic valid;
        logic [11:0] coarse;
        logic [11:0] fine;
    } ifcr_peak_t;

    typedef enum logic [2:0] {
        OC_IDLE = 3'b001,
        OC_DRIVE = 3'b010,
        OC_DONE = 3'b100
    } ifcr_oc_state_t;
endpackage

/* File: hdl/ifcr_regs.sv */
// Front-end register bank: gain readback, control, coil test, coarse routing, AHB-Lite slave
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
module ifcr_regs import ifcr_pkg::*; #(
    parameter int unsigned GAIN_PERIOD = GAIN_PERIOD_DEF,
    parameter logic [11:0] PEAK_HIGH = PEAK_HIGH_DEF,
    parameter logic [11:0] PEAK_LOW = PEAK_LOW_DEF
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire ifcr_peak_t peak,
    input wire logic osc_gain_update,
    input wire logic amp_offset_update,
    input wire logic channel_select,
    input wire logic [7:0] coil_open,
    output logic [5:0] coarse_gain_code,
    output logic [5:0] fine_gain_code,
    output logic extrapolation_hold,
    output logic coil_test_drive,
    output logic turn_count_clear,
    output ifcr_rect_route_t [3:0] rect_route,
    output logic irq
);
    localparam int GP_W = $clog2(GAIN_PERIOD);
    localparam int OC_W = $clog2(COIL_SETTLE_CYC + 1);
    localparam int OC_WAIT = COIL_SETTLE_CYC;

    if (GAIN_PERIOD < 2) begin : g_bad_period
        $error("GAIN_PERIOD must be at least 2");
    end
    if (PEAK_LOW >= PEAK_HIGH) begin : g_bad_peak
        $error("PEAK_LOW must be below PEAK_HIGH");
    end

    // Bus decode
    logic req;
    logic [7:0] req_idx;
    logic rd_req;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic ctrl_wr;
    logic [15:0] wdata;
    assign req = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign req_idx = haddr[ADDR_IDX_LSB +: 8];
    assign rd_req = req && !hwrite;
    assign wdata = hwdata[15:0];
    assign ctrl_wr = wr_pend && (wr_idx == IDX_CTRL);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_pend <= 1'b0;
            wr_idx <= 8'h00;
        end else begin
            wr_pend <= req && hwrite;
            wr_idx <= req_idx;
        end
    end

    // Gain adjustment, one loop per gain code: index 0 coarse, index 1 fine
    logic [GP_W-1:0] tick_cnt;
    logic gain_tick;
    logic [1:0] gain_moved;
    logic gain_step;
    logic [5:0] gain_code [2];
    logic [11:0] peak_in [2];
    assign gain_tick = (tick_cnt == GP_W'(GAIN_PERIOD - 1));
    assign peak_in[0] = peak.coarse;
    assign peak_in[1] = peak.fine;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt <= '0;
        end else if (gain_tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + GP_W'(1);
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_gain
        logic [11:0] peak_max;
        logic [11:0] next_peak_max;
        always_comb begin
            next_peak_max = peak_max;
            if (peak.valid && peak_in[g] > peak_max) begin
                next_peak_max = peak_in[g];
            end
        end
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                peak_max <= 12'h000;
                gain_code[g] <= CODE_RESET;
                gain_moved[g] <= 1'b0;
            end else if (gain_tick) begin
                peak_max <= 12'h000;
                gain_moved[g] <= 1'b0;
                // Higher code gives more gain, so back off on large peaks
                if (next_peak_max > PEAK_HIGH && gain_code[g] != CODE_RESET) begin
                    gain_code[g] <= gain_code[g] - 6'h01;
                    gain_moved[g] <= 1'b1;
                end else if (next_peak_max < PEAK_LOW && gain_code[g] != CODE_MAX) begin
                    gain_code[g] <= gain_code[g] + 6'h01;
                    gain_moved[g] <= 1'b1;
                end
            end else begin
                peak_max <= next_peak_max;
                gain_moved[g] <= 1'b0;
            end
        end
        a_gain_rises_low: assert property (@(posedge clk) disable iff (!reset_n)
            gain_tick && next_peak_max < PEAK_LOW && gain_code[g] != CODE_MAX
            |=> gain_code[g] == $past(gain_code[g]) + 6'h01)
            else $error("gain code did not rise on a low peak");
    end

    assign gain_step = |gain_moved;
    assign coarse_gain_code = gain_code[0];
    assign fine_gain_code = gain_code[1];

    // Control register
    logic ext_dis;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_dis <= CTRL_RESET[CTRL_EXT_DIS_BIT];
        end else if (ctrl_wr) begin
            ext_dis <= wdata[CTRL_EXT_DIS_BIT];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            extrapolation_hold <= 1'b0;
        end else begin
            extrapolation_hold <= ext_dis &&
                (gain_step || osc_gain_update || amp_offset_update);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            turn_count_clear <= CTRL_RESET[CTRL_TURN_CLR_BIT];
        end else begin
            turn_count_clear <= ctrl_wr && wdata[CTRL_TURN_CLR_BIT];
        end
    end

    // Coil open inputs: three-stage synchroniser and agreement filter
    logic [7:0] open_s1;
    logic [7:0] open_s2;
    logic [7:0] open_s3;
    logic [7:0] open_filt;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            open_s1 <= 8'h00;
            open_s2 <= 8'h00;
            open_s3 <= 8'h00;
            open_filt <= 8'h00;
        end else begin
            open_s1 <= coil_open;
            open_s2 <= open_s1;
            open_s3 <= open_s2;
            for (int i = 0; i < NUM_COILS; i++) begin
                if (open_s2[i] == open_s3[i]) begin
                    open_filt[i] <= open_s3[i];
                end
            end
        end
    end

    // Open-coil test sequencer
    ifcr_oc_state_t oc_state;
    logic [OC_W-1:0] oc_cnt;
    logic oc_start;
    logic test_done;
    logic coil_run;
    logic open_coil_found;
    assign oc_start = ctrl_wr && wdata[CTRL_COIL_RUN_BIT] && (oc_state == OC_IDLE);
    assign test_done = (oc_state == OC_DONE);
    assign coil_run = (oc_state != OC_IDLE);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oc_state <= OC_IDLE;
            oc_cnt <= '0;
        end else begin
            case (oc_state)
                OC_IDLE: begin
                    oc_cnt <= '0;
                    if (oc_start) begin
                        oc_state <= OC_DRIVE;
                    end
                end
                OC_DRIVE: begin
                    oc_cnt <= oc_cnt + OC_W'(1);
                    if (oc_cnt == OC_W'(COIL_SETTLE_CYC - 1)) begin
                        oc_state <= OC_DONE;
                    end
                end
                OC_DONE: begin
                    oc_state <= OC_IDLE;
                end
                default: begin
                    oc_state <= OC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            coil_test_drive <= 1'b0;
        end else begin
            coil_test_drive <= (oc_state == OC_IDLE) ? oc_start :
                               (oc_state == OC_DRIVE) &&
                               (oc_cnt != OC_W'(COIL_SETTLE_CYC - 1));
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            open_coil_found <= REG_RESET[STAT_OPEN_BIT];
        end else if (oc_start) begin
            open_coil_found <= 1'b0;
        end else if (test_done) begin
            open_coil_found <= |open_filt;
        end
    end

    // Coarse routing register and decode
    logic [15:0] route;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            route <= ROUTE_RESET;
        end else if (wr_pend && wr_idx == IDX_ROUTE) begin
            route <= wdata;
        end
    end

    for (genvar r = 0; r < NUM_RECT; r++) begin : g_rect
        logic [1:0] pos_sel;
        logic [1:0] neg_sel;
        assign pos_sel = route[4*r+2 +: 2];
        assign neg_sel = route[4*r +: 2];
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                rect_route[r] <= '0;
            end else begin
                rect_route[r].pos_pin <= {channel_select, pos_sel};
                rect_route[r].neg_pin <= {channel_select, neg_sel};
                rect_route[r].neg_dc <= (pos_sel == neg_sel);
            end
        end
        a_neg_to_dc: assert property (@(posedge clk) disable iff (!reset_n)
            $past(reset_n) |-> rect_route[r].neg_dc == ($past(pos_sel) == $past(neg_sel)))
            else $error("negative input DC tie wrong");
        a_pin_decode: assert property (@(posedge clk) disable iff (!reset_n)
            $past(reset_n) |->
            rect_route[r].pos_pin == {$past(channel_select), $past(route[4*r+2 +: 2])}
            && rect_route[r].neg_pin == {$past(channel_select), $past(route[4*r +: 2])})
            else $error("sense pin decode wrong");
    end

    // Interrupt status and mask
    logic [2:0] irq_set;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic irq_clr;
    assign irq_set = {gain_step, test_done && (|open_filt), test_done};
    assign irq_clr = rd_req && (req_idx == IDX_IRQ_STAT);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat <= IRQ_RESET;
        end else begin
            irq_stat <= (irq_clr ? IRQ_RESET : irq_stat) | irq_set;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask <= IRQ_RESET;
        end else if (wr_pend && wr_idx == IDX_IRQ_MASK) begin
            irq_mask <= wdata[IRQ_W-1:0];
        end
    end
    assign irq = |(irq_stat & irq_mask);

    // Read mux; reserved and unmapped bits read zero
    logic [15:0] rd_word;
    always_comb begin
        rd_word = REG_RESET;
        case (req_idx)
            IDX_GAIN: begin
                rd_word[GAIN_COARSE_LSB +: CODE_W] = gain_code[0];
                rd_word[GAIN_FINE_LSB +: CODE_W] = gain_code[1];
            end
            IDX_CTRL: begin
                rd_word[CTRL_EXT_DIS_BIT] = ext_dis;
                rd_word[CTRL_COIL_RUN_BIT] = coil_run;
                rd_word[CTRL_TURN_CLR_BIT] = turn_count_clear;
            end
            IDX_STAT: rd_word[STAT_OPEN_BIT] = open_coil_found;
            IDX_ROUTE: rd_word = route;
            IDX_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_stat;
            IDX_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask;
            default: rd_word = REG_RESET;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= 32'h00000000;
        end else if (rd_req) begin
            hrdata <= {16'h0000, rd_word};
        end
    end

    // Checks
    logic first_cycle;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            first_cycle <= 1'b1;
        end else begin
            first_cycle <= 1'b0;
        end
    end

    sequence s_oc_start;
        oc_start;
    endsequence
    sequence s_oc_finish;
        coil_run ##OC_WAIT test_done ##1 !coil_run;
    endsequence

    a_gain_read_only: assert property (@(posedge clk) disable iff (!reset_n)
        wr_pend && wr_idx == IDX_GAIN && !gain_tick
        |=> $stable(coarse_gain_code) && $stable(fine_gain_code))
        else $error("gain code changed by a bus write");
    a_gain_on_tick: assert property (@(posedge clk) disable iff (!reset_n)
        !$stable(coarse_gain_code) || !$stable(fine_gain_code)
        |-> $past(gain_tick))
        else $error("gain code changed off the adjust tick");
    a_coarse_field: assert property (@(posedge clk) disable iff (!reset_n)
        rd_req && req_idx == IDX_GAIN
        |=> hrdata[13:8] == $past(coarse_gain_code) && hrdata[15:14] == 2'h0)
        else $error("coarse gain readback wrong");
    a_fine_field: assert property (@(posedge clk) disable iff (!reset_n)
        rd_req && req_idx == IDX_GAIN
        |=> hrdata[5:0] == $past(fine_gain_code) && hrdata[7:6] == 2'h0)
        else $error("fine gain readback wrong");
    a_reset_values: assert property (@(posedge clk) disable iff (!reset_n)
        first_cycle |-> !ext_dis && !coil_run && !turn_count_clear
        && !open_coil_found && route == ROUTE_RESET)
        else $error("register not at reset value");
    a_extrap_gate: assert property (@(posedge clk) disable iff (!reset_n)
        ext_dis && (gain_step || osc_gain_update || amp_offset_update) |=> extrapolation_hold)
        else $error("extrapolation not held off");
    a_extrap_needs: assert property (@(posedge clk) disable iff (!reset_n)
        extrapolation_hold |-> $past(ext_dis))
        else $error("extrapolation held without disable bit");
    a_coil_test_run: assert property (@(posedge clk) disable iff (!reset_n)
        s_oc_start |=> s_oc_finish)
        else $error("open coil test did not run its full span");
    a_turn_clear: assert property (@(posedge clk) disable iff (!reset_n)
        ctrl_wr && wdata[CTRL_TURN_CLR_BIT]
        |=> turn_count_clear ##1 !turn_count_clear)
        else $error("turn clear not a single pulse");
    a_open_flag: assert property (@(posedge clk) disable iff (!reset_n)
        test_done |=> open_coil_found == $past(|open_filt))
        else $error("open coil flag wrong");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
        rd_req && (req_idx == IDX_CTRL || req_idx == IDX_STAT)
        |=> hrdata[31:16] == 16'h0000 && hrdata[14] == 1'b0 && hrdata[12] == 1'b0
        && hrdata[10:0] == 11'h000)
        else $error("reserved bits not zero");
endmodule

/* File: bench/ifcr_testbench.sv */
// Self-checking testbench of the inductive front-end register bank
`timescale 1ns/1ps
module testbench import ifcr_pkg::*; ;
    localparam int unsigned GP = 8;
    logic clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    ifcr_peak_t peak;
    logic osc_gain_update, amp_offset_update, channel_select;
    logic [7:0] coil_open;
    logic [5:0] coarse_gain_code, fine_gain_code;
    logic extrapolation_hold, coil_test_drive, turn_count_clear;
    ifcr_rect_route_t [3:0] rect_route;
    int miscompares = 0;
    int n_tests = 0;
    int hold_count = 0;
    int clear_count = 0;
    int h0;
    logic [7:0] idx_list [6] = '{IDX_GAIN, IDX_CTRL, IDX_STAT, IDX_ROUTE,
                                 IDX_IRQ_STAT, IDX_IRQ_MASK};
    logic [15:0] route_vals [2] = '{16'h05AF, 16'h1B4E};

    assign hready = hreadyout;

    ifcr_regs #(.GAIN_PERIOD(GP)) dut (.clk(clk), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .peak(peak), .osc_gain_update(osc_gain_update),
        .amp_offset_update(amp_offset_update), .channel_select(channel_select),
        .coil_open(coil_open), .coarse_gain_code(coarse_gain_code),
        .fine_gain_code(fine_gain_code), .extrapolation_hold(extrapolation_hold),
        .coil_test_drive(coil_test_drive), .turn_count_clear(turn_count_clear),
        .rect_route(rect_route), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
    end

    // Pulse counters on the one-cycle outputs
    always @(posedge clk) begin
        if (extrapolation_hold === 1'b1) hold_count++;
        if (turn_count_clear === 1'b1) clear_count++;
    end

    task automatic summarize();
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One single AHB-Lite word transfer, address phase then data phase
    task automatic ahb(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rdv);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {22'h000000, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? wd : 32'h00000000;
        do @(posedge clk); while (hready !== 1'b1);
        rdv = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] d);
        logic [31:0] dummy;
        ahb(idx, 1'b1, {16'h0000, d}, dummy);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp, input string name);
        logic [31:0] v;
        ahb(idx, 1'b0, 32'h00000000, v);
        check(name, v, {16'h0000, exp});
    endtask

    task automatic set_peak(input logic [11:0] c, input logic [11:0] f);
        peak <= '{valid: 1'b1, coarse: c, fine: f};
    endtask

    task automatic pulse_updates();
        @(posedge clk);
        osc_gain_update <= 1'b1;
        @(posedge clk);
        osc_gain_update <= 1'b0;
        amp_offset_update <= 1'b1;
        @(posedge clk);
        amp_offset_update <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    function automatic logic [27:0] route_exp(input logic [15:0] v, input logic cs);
        ifcr_rect_route_t [3:0] r;
        for (int i = 0; i < 4; i++) begin
            r[i].pos_pin = {cs, v[4 * i + 2 +: 2]};
            r[i].neg_pin = {cs, v[4 * i +: 2]};
            r[i].neg_dc = (v[4 * i + 2 +: 2] == v[4 * i +: 2]);
        end
        return r;
    endfunction

    initial begin
        #(CLK_PERIOD_NS * 20000);
        miscompares++;
        summarize();
    end

    initial begin
        reset_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        // Mid-range peaks keep the gain loop still until a scenario moves them
        peak = '{valid: 1'b1, coarse: 12'hA00, fine: 12'hA00};
        osc_gain_update = 1'b0;
        amp_offset_update = 1'b0;
        channel_select = 1'b0;
        coil_open = 8'h00;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        // Reset values
        for (int i = 0; i < 6; i++) rd_chk(idx_list[i], 16'h0000, "reset value");
        // Read-only gain readback and an unmapped place
        wr(IDX_GAIN, 16'hFFFF);
        wr(8'h0F, 16'hFFFF);
        rd_chk(IDX_GAIN, 16'h0000, "gain after write");
        rd_chk(8'h0F, 16'h0000, "unmapped read");
        // Coarse routing decode for both channel selects
        for (int v = 0; v < 2; v++) begin
            wr(IDX_ROUTE, route_vals[v]);
            rd_chk(IDX_ROUTE, route_vals[v], "route readback");
            for (int c = 0; c < 2; c++) begin
                channel_select <= c[0];
                repeat (3) @(posedge clk);
                check("rect_route", {4'h0, rect_route},
                      {4'h0, route_exp(route_vals[v], c[0])});
            end
        end
        // Automatic gain stepping: low coarse peaks raise coarse, high fine peaks hold fine at 0
        set_peak(12'h100, 12'hF00);
        for (int i = 0; i < 200 && coarse_gain_code !== 6'h01; i++) @(posedge clk);
        set_peak(12'hA00, 12'hA00);
        check("coarse code", {26'h0, coarse_gain_code}, 32'h1);
        check("fine code", {26'h0, fine_gain_code}, 32'h0);
        rd_chk(IDX_GAIN, 16'h0100, "gain readback coarse");
        set_peak(12'hF00, 12'h100);
        for (int i = 0; i < 200 && fine_gain_code !== 6'h01; i++) @(posedge clk);
        set_peak(12'hA00, 12'hA00);
        repeat (2 * GP) @(posedge clk);
        rd_chk(IDX_GAIN, 16'h0001, "gain readback fine");
        rd_chk(IDX_IRQ_STAT, 16'h0004, "irq gain event");
        rd_chk(IDX_IRQ_STAT, 16'h0000, "irq clear on read");
        // Reserved control bits, turn counter clear, extrapolation disable
        wr(IDX_CTRL, 16'h5000);
        rd_chk(IDX_CTRL, 16'h0000, "ctrl reserved");
        h0 = clear_count;
        wr(IDX_CTRL, 16'h8800);
        repeat (4) @(posedge clk);
        check("turn clear pulses", clear_count - h0, 32'h1);
        rd_chk(IDX_CTRL, 16'h8000, "ctrl after turn clear");
        h0 = hold_count;
        pulse_updates();
        check("hold pulses enabled", hold_count - h0, 32'h2);
        wr(IDX_CTRL, 16'h0000);
        h0 = hold_count;
        pulse_updates();
        check("hold pulses disabled", hold_count - h0, 32'h0);
        // Open-coil test, first with all coils present, then with one open
        for (int k = 0; k < 2; k++) begin
            coil_open <= (k == 1) ? 8'h10 : 8'h00;
            repeat (10) @(posedge clk);
            wr(IDX_CTRL, 16'h2000);
            repeat (2) @(posedge clk);
            check("coil drive", {31'h0, coil_test_drive}, 32'h1);
            rd_chk(IDX_CTRL, 16'h2000, "ctrl while running");
            for (int i = 0; i < 400 && coil_test_drive !== 1'b0; i++) @(posedge clk);
            repeat (3) @(posedge clk);
            rd_chk(IDX_CTRL, 16'h0000, "ctrl after test");
            rd_chk(IDX_STAT, (k == 1) ? 16'h2000 : 16'h0000, "open coil flag");
            if (k == 0) begin
                check("irq masked", {31'h0, irq}, 32'h0);
                wr(IDX_IRQ_MASK, 16'h0003);
                rd_chk(IDX_IRQ_MASK, 16'h0003, "irq mask");
            end
            repeat (2) @(posedge clk);
            check("irq raised", {31'h0, irq}, 32'h1);
            rd_chk(IDX_IRQ_STAT, (k == 1) ? 16'h0003 : 16'h0001, "irq test events");
            repeat (2) @(posedge clk);
            check("irq cleared", {31'h0, irq}, 32'h0);
        end
        summarize();
    end
endmodule
